// ===== verilog/wtcc_consts.svh
`ifndef WTCC_CONSTS_SVH
`define WTCC_CONSTS_SVH
// ----------------------------------------------------------------
// Address layout and sizes
// ----------------------------------------------------------------
`define WTCC_ADDR_W      30
`define WTCC_DM_IDX_W    13
`define WTCC_SA_IDX_W    12
`define WTCC_DM_TAG_W    17
`define WTCC_SA_TAG_W    18
`define WTCC_DM_LINES    8192
`define WTCC_SA_LINES    4096
`define WTCC_BYTES       4
`endif

// ===== verilog/wtcc_pkg.sv
package wtcc_pkg;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic {WTCC_READ, WTCC_WRITE} wtcc_dir_e;
  typedef struct packed {
    logic [29:0] addr;
    logic [31:0] data;
    logic [3:0]  be_n;
    logic        write;
  } wtcc_cyc_s;
  typedef struct packed {
    logic [1:0]  oe_n;
    logic [1:0]  we_n;
    logic [3:0]  byte_sel_n;
  } wtcc_sram_s;
endpackage : wtcc_pkg

// ===== verilog/wtcc_tag_dir.sv
`timescale 1ns/1ps
`default_nettype none
`include "wtcc_consts.svh"
// Tag directory: per-line tags for both banks, compared in parallel
module wtcc_tag_dir
  import wtcc_pkg::*;
#(
  parameter int LINES = `WTCC_SA_LINES,
  parameter int TAG_W = `WTCC_SA_TAG_W + 1
) (
  input  wire logic                     mclk_i,
  input  wire logic                     rst_i,
  input  wire logic                     two_way_i,
  input  wire logic [29:0]              addr_i,
  input  wire logic                     fill_i,
  input  wire logic                     fill_bank_i,
  output logic      [1:0]               hit_o
);
  // Index and tag slicing below are fixed, so other sizes are refused
  if (LINES != `WTCC_SA_LINES || TAG_W != `WTCC_SA_TAG_W + 1) begin : g_bad_size
    $error("wtcc_tag_dir: LINES and TAG_W are fixed by the address split");
  end
  logic [11:0]      idx;
  logic [TAG_W-1:0] tag;
  logic [1:0]       valid_ff [LINES];
  // Direct mapped folds address bit 12 into the bank choice, bank = a[12]
  assign idx = addr_i[11:0];
  assign tag = two_way_i ? {1'b0, addr_i[29:12]} : {2'b00, addr_i[29:13]};
  generate
    for (genvar b = 0; b < 2; b++) begin : g_bank
      // Each bank owns its tag store, so every array has one writer
      logic             sel;
      logic             hit_b;
      logic [TAG_W-1:0] tag_ff [LINES];
      assign sel   = two_way_i ? 1'b1 : (addr_i[12] == 1'(b));
      assign hit_b = sel & valid_ff[idx][b] & (tag_ff[idx] == tag);
      // Only a read-miss fill allocates a line
      always_ff @(posedge mclk_i) begin
        if (fill_i && (two_way_i ? (fill_bank_i == 1'(b)) : sel)) begin
          tag_ff[idx] <= tag;
        end
      end
    end
  endgenerate
  assign hit_o = {g_bank[1].hit_b, g_bank[0].hit_b};
  // Valid bits
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      for (int i = 0; i < LINES; i++) valid_ff[i] <= 2'b00;
    end else if (fill_i) begin
      if (two_way_i) valid_ff[idx][fill_bank_i] <= 1'b1;
      else valid_ff[idx][addr_i[12]] <= 1'b1;
    end
  end
endmodule : wtcc_tag_dir
`default_nettype wire

// ===== verilog/wtcc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "wtcc_consts.svh"
module wtcc_ctrl
  import wtcc_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        two_way_i,
  input  wire logic        proc_addr_strobe_n_i,
  input  wire logic [29:0] proc_addr_i,
  input  wire logic [3:0]  proc_be_n_i,
  input  wire logic        proc_write_i,
  input  wire logic [31:0] proc_data_i,
  input  wire logic        sys_bus_busy_i,
  input  wire logic        sys_ready_n_i,
  output logic             cache_addr_latch_en_o,
  output logic             next_addr_request_n_o,
  output logic             proc_ready_out_n_o,
  output logic             sys_addr_strobe_n_o,
  output logic             sys_reg_en_o,
  output wtcc_cyc_s        sys_cyc_o,
  output wtcc_sram_s       sram_o,
  output logic             miss_o
);
  // ----------------------------------------------------------------
  // Pin synchronisers for system-side levels
  // ----------------------------------------------------------------
  logic [1:0] busy_sync_ff, nxt_busy_sync;
  logic [1:0] rdy_sync_ff,  nxt_rdy_sync;
  logic       bus_busy, sys_rdy;
  always_comb begin
    nxt_busy_sync = {busy_sync_ff[0], sys_bus_busy_i};
    nxt_rdy_sync  = {rdy_sync_ff[0], ~sys_ready_n_i};
  end
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      busy_sync_ff <= 2'b00;
      rdy_sync_ff  <= 2'b00;
    end else begin
      busy_sync_ff <= nxt_busy_sync;
      rdy_sync_ff  <= nxt_rdy_sync;
    end
  end
  assign bus_busy = busy_sync_ff[1];
  assign sys_rdy  = rdy_sync_ff[1];

  // ----------------------------------------------------------------
  // Tag compare
  // ----------------------------------------------------------------
  logic [1:0]  hit_vec;
  logic [29:0] dir_addr;
  logic       hit, start, fill, fill_bank, lru_ff, nxt_lru;
  assign start = ~proc_addr_strobe_n_i;
  wtcc_tag_dir #(
    .LINES (`WTCC_SA_LINES),
    .TAG_W (`WTCC_SA_TAG_W + 1)
  ) u_tags (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .two_way_i   (two_way_i),
    .addr_i      (dir_addr),
    .fill_i      (fill),
    .fill_bank_i (fill_bank),
    .hit_o       (hit_vec)
  );
  assign hit = |hit_vec;

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_RD_HIT, S_RD_MISS, S_RD_WAIT} wtcc_st_e;
  typedef enum logic [1:0] {P_IDLE, P_WAIT_BUS, P_WAIT_RDY} wtcc_post_e;
  wtcc_st_e   st_ff, nxt_st;
  wtcc_post_e post_ff, nxt_post;
  wtcc_cyc_s  cyc_ff, nxt_cyc;
  wtcc_sram_s sram_ff, nxt_sram;
  logic       cale_ff, nxt_cale, na_n_ff, nxt_na_n, rdy_n_ff, nxt_rdy_n;
  logic       sys_addr_strobe_n_n_ff, nxt_sys_addr_strobe_n_n, reg_en_ff, nxt_reg_en, miss_ff, nxt_miss;
  logic       accept;

  // Single latch set: a new write or read miss waits while a write is posted; a read hit is taken
  assign accept    = start && (st_ff == S_IDLE) &&
                     (post_ff == P_IDLE || (!proc_write_i && hit));
  assign fill      = (st_ff == S_RD_WAIT) && sys_rdy;
  assign fill_bank = lru_ff;
  // Fill tags the latched miss address; the pins may already carry the next one
  assign dir_addr  = fill ? cyc_ff.addr : proc_addr_i;

  always_comb begin
    nxt_st     = st_ff;
    nxt_post   = post_ff;
    nxt_cyc    = cyc_ff;
    nxt_cale   = 1'b0;
    nxt_na_n   = 1'b1;
    nxt_rdy_n  = 1'b1;
    nxt_sys_addr_strobe_n_n = 1'b1;
    nxt_reg_en = reg_en_ff;
    nxt_miss   = 1'b0;
    nxt_lru    = lru_ff;
    nxt_sram   = '{oe_n: 2'b11, we_n: 2'b11, byte_sel_n: 4'hF};
    if (accept) begin
      nxt_cale = 1'b1;
      if (proc_write_i) begin
        nxt_cyc    = '{addr: proc_addr_i, data: proc_data_i,
                       be_n: proc_be_n_i, write: 1'b1};
        nxt_reg_en = 1'b1;
        nxt_rdy_n  = 1'b0;
        nxt_post   = P_WAIT_BUS;
        nxt_miss   = ~hit;
        if (hit) begin
          nxt_sram.we_n       = ~(two_way_i ? hit_vec : 2'b11);
          nxt_sram.byte_sel_n = proc_be_n_i;
        end
      end else if (hit) begin
        nxt_st               = S_RD_HIT;
        nxt_sram.oe_n        = ~(two_way_i ? hit_vec : 2'b11); // both sets if direct
        nxt_sram.byte_sel_n  = proc_be_n_i;
      end else begin
        nxt_cyc    = '{addr: proc_addr_i, data: '0, be_n: proc_be_n_i, write: 1'b0};
        nxt_reg_en = 1'b1;
        nxt_na_n   = 1'b0;
        nxt_miss   = 1'b1;
        nxt_st     = S_RD_MISS;
      end
    end
    case (st_ff)
      S_RD_HIT: begin
        nxt_rdy_n = 1'b0;
        nxt_st    = S_IDLE;
      end
      S_RD_MISS: begin
        if (post_ff == P_IDLE && !bus_busy) begin
          nxt_sys_addr_strobe_n_n = 1'b0;
          nxt_st     = S_RD_WAIT;
        end
      end
      S_RD_WAIT: begin
        if (sys_rdy) begin
          nxt_rdy_n           = 1'b0;
          nxt_sram.we_n       = two_way_i ? ~{lru_ff, ~lru_ff} : 2'b00;
          nxt_sram.byte_sel_n = 4'h0;
          nxt_lru             = ~lru_ff;
          nxt_reg_en          = 1'b0;
          nxt_st              = S_IDLE;
        end
      end
      default: ;
    endcase
    case (post_ff)
      P_WAIT_BUS: begin
        if (!bus_busy && !accept) begin
          nxt_sys_addr_strobe_n_n = 1'b0;
          nxt_post   = P_WAIT_RDY;
        end
      end
      P_WAIT_RDY: begin
        if (sys_rdy) begin
          nxt_post   = P_IDLE;
          nxt_reg_en = 1'b0;
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_ff     <= S_IDLE;
      post_ff   <= P_IDLE;
      cyc_ff    <= '0;
      cale_ff   <= 1'b0;
      na_n_ff   <= 1'b1;
      rdy_n_ff  <= 1'b1;
      sys_addr_strobe_n_n_ff <= 1'b1;
      reg_en_ff <= 1'b0;
      miss_ff   <= 1'b0;
      lru_ff    <= 1'b0;
      sram_ff   <= '{oe_n: 2'b11, we_n: 2'b11, byte_sel_n: 4'hF};
    end else begin
      st_ff     <= nxt_st;
      post_ff   <= nxt_post;
      cyc_ff    <= nxt_cyc;
      cale_ff   <= nxt_cale;
      na_n_ff   <= nxt_na_n;
      rdy_n_ff  <= nxt_rdy_n;
      sys_addr_strobe_n_n_ff <= nxt_sys_addr_strobe_n_n;
      reg_en_ff <= nxt_reg_en;
      miss_ff   <= nxt_miss;
      lru_ff    <= nxt_lru;
      sram_ff   <= nxt_sram;
    end
  end

  assign cache_addr_latch_en_o = cale_ff;
  assign next_addr_request_n_o = na_n_ff;
  assign proc_ready_out_n_o    = rdy_n_ff;
  assign sys_addr_strobe_n_o   = sys_addr_strobe_n_n_ff;
  assign sys_reg_en_o          = reg_en_ff;
  assign sys_cyc_o             = cyc_ff;
  assign sram_o                = sram_ff;
  assign miss_o                = miss_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_post_write;
    accept && proc_write_i;
  endsequence
  chk_latch_first_clk: assert property (accept |=> cache_addr_latch_en_o)
    else $error("address latch not pulsed after strobe");
  chk_post_ready: assert property (s_post_write |=> !proc_ready_out_n_o)
    else $error("posted write not readied next clock");
  chk_miss_na: assert property (accept && !proc_write_i && !hit
      |=> !next_addr_request_n_o)
    else $error("miss without next address request");
  chk_hit_no_na: assert property (accept && hit |=> next_addr_request_n_o)
    else $error("hit requested pipelining");
  chk_rdhit_nobus: assert property (accept && hit && !proc_write_i && post_ff == P_IDLE
      |=> sys_addr_strobe_n_o ##1 sys_addr_strobe_n_o && !proc_ready_out_n_o)
    else $error("read hit touched bus or late data");
  chk_wrmiss_nowe: assert property (accept && proc_write_i && !hit |=> &sram_o.we_n)
    else $error("write miss wrote cache");
  chk_post_sys_addr_strobe_n: assert property (post_ff == P_WAIT_BUS && !bus_busy && !accept
      |=> !sys_addr_strobe_n_o)
    else $error("posted write not started on free bus");
  chk_one_post: assert property (post_ff != P_IDLE && start && proc_write_i
      |=> !cache_addr_latch_en_o)
    else $error("second write posted");
  chk_rdmiss_fill: assert property (st_ff == S_RD_WAIT && sys_rdy
      |=> !proc_ready_out_n_o && !(&sram_o.we_n))
    else $error("read miss fill not with ready");
  chk_rdmiss_hold: assert property ((st_ff == S_RD_MISS)
      || (st_ff == S_RD_WAIT && !sys_rdy) |=> proc_ready_out_n_o)
    else $error("ready before memory answered");
  chk_post_absorb: assert property (post_ff == P_WAIT_RDY && sys_rdy && st_ff == S_IDLE
      |=> proc_ready_out_n_o || $past(accept))
    else $error("posted ready leaked to processor");
  chk_dm_both: assert property (!two_way_i && accept && hit
      |=> sram_o.oe_n[0] == sram_o.oe_n[1] && sram_o.we_n[0] == sram_o.we_n[1])
    else $error("direct mapped strobes differ");
endmodule : wtcc_ctrl
`default_nettype wire

// ===== tb/wtcc_sys_model.sv
`timescale 1ns/1ps
`default_nettype none
// System memory side: a wait-state counter answers each system strobe
module wtcc_sys_model (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       busy_cmd_i,
  input  wire logic [3:0] waits_i,
  input  wire logic       sys_addr_strobe_n_i,
  output logic            sys_bus_busy_o,
  output logic            sys_ready_n_o
);
  // ----------------------------------------
  // Cycle timing
  // ----------------------------------------
  int cnt_ff;
  // Busy while our cycle runs or another master holds the bus
  assign sys_bus_busy_o = busy_cmd_i | (cnt_ff != 0);
  // One low ready pulse ends every cycle, after waits_i wait states
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_ff <= 0;
      sys_ready_n_o <= 1'b1;
    end else begin
      sys_ready_n_o <= ~(cnt_ff == 1);
      if (!sys_addr_strobe_n_i && cnt_ff == 0) cnt_ff <= int'(waits_i) + 1;
      else if (cnt_ff != 0) cnt_ff <= cnt_ff - 1;
    end
  end
endmodule : wtcc_sys_model
`default_nettype wire

// ===== tb/wtcc_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module wtcc_ctrl_bench import wtcc_pkg::*; ();
  logic        mclk_i, rst_i, two_way, ads_n, wr, busy_cmd, sys_busy, sys_rdy_n;
  logic        lat_en, na_n, rdy_n, sys_as_n, reg_en, miss, was_miss, reg_at;
  logic [29:0] addr;
  logic [3:0]  be_n, waits;
  logic [31:0] data;
  wtcc_cyc_s   cyc, cyc_at;
  wtcc_sram_s  sram, sr_hit, sr_rdy;
  int          n_fail = 0, cmp_count = 0, t_lat, t_na, t_rdy, t_sys, t_sr, n_rdy;
  // ----------------------------------------
  // Clock, design and memory side
  // ----------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  wtcc_ctrl i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .two_way_i(two_way),
    .proc_addr_strobe_n_i(ads_n), .proc_addr_i(addr), .proc_be_n_i(be_n),
    .proc_write_i(wr), .proc_data_i(data), .sys_bus_busy_i(sys_busy),
    .sys_ready_n_i(sys_rdy_n), .cache_addr_latch_en_o(lat_en),
    .next_addr_request_n_o(na_n), .proc_ready_out_n_o(rdy_n),
    .sys_addr_strobe_n_o(sys_as_n), .sys_reg_en_o(reg_en), .sys_cyc_o(cyc),
    .sram_o(sram), .miss_o(miss));
  wtcc_sys_model i_mem (.mclk_i(mclk_i), .rst_i(rst_i), .busy_cmd_i(busy_cmd),
    .waits_i(waits), .sys_addr_strobe_n_i(sys_as_n), .sys_bus_busy_o(sys_busy),
    .sys_ready_n_o(sys_rdy_n));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  // Direct mode strobes both banks, two-way mode exactly one
  function automatic logic [31:0] bank_ok(input logic [1:0] s);
    return (two_way ? (s == 2'b01 || s == 2'b10) : s == 2'b00) ? 32'h1 : 32'h0;
  endfunction : bank_ok
  // One reference; strobe held until latched, busy dropped at cycle rel
  task automatic do_ref(input logic w, input logic [29:0] a, input logic [3:0] be,
                        input int len, input int rel);
    t_lat = -1; t_na = -1; t_rdy = -1; t_sys = -1; t_sr = -1; n_rdy = 0;
    was_miss = 1'b0;
    reg_at = 1'b0;
    @(posedge mclk_i);
    // Busy crosses a two-flop synchroniser, so it rises ahead of the strobe
    busy_cmd <= (rel > 0);
    if (rel > 0) repeat (2) @(posedge mclk_i);
    ads_n <= 1'b0;
    wr <= w;
    addr <= a;
    be_n <= be;
    data <= {2'h0, a};
    for (int i = 1; i <= len; i++) begin
      @(posedge mclk_i);
      if (t_lat > 0) ads_n <= 1'b1;
      if (i == rel) busy_cmd <= 1'b0;
      #1;
      if (lat_en === 1'b1 && t_lat < 0) t_lat = i;
      if (na_n === 1'b0 && t_na < 0) t_na = i;
      if (miss === 1'b1) was_miss = 1'b1;
      if (sys_as_n === 1'b0 && t_sys < 0) begin
        t_sys = i;
        cyc_at = cyc;
        reg_at = reg_en;
      end
      if ((sram.oe_n & sram.we_n) != 2'b11 && t_sr < 0) begin
        t_sr = i;
        sr_hit = sram;
      end
      if (rdy_n === 1'b0) begin
        n_rdy++;
        if (t_rdy < 0) sr_rdy = sram;
        if (t_rdy < 0) t_rdy = i;
      end
    end
    if (t_lat < 0 || t_rdy < 0) begin
      n_fail++;
      $display("[ERR] reference end expected ready seen none");
      results();
    end
  endtask : do_ref
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Cold read misses and fills, then the same line hits
  task automatic s_read(input logic [29:0] a);
    do_ref(1'b0, a, 4'h0, 30, 0);
    chk("miss latch", 32'h1, t_lat);
    chk("miss flag", 32'h1, was_miss);
    chk("next addr", 32'h1, t_na);
    chk("sys addr", a, cyc_at.addr);
    chk("sys regs", 32'h1, reg_at);
    chk("ready after sys", 32'h1, t_rdy > t_sys && t_sys > 0);
    chk("fill bytes", 32'h0, sr_rdy.byte_sel_n);
    chk("fill bank", 32'h1, bank_ok(sr_rdy.we_n));
    chk("regs freed", 32'h0, reg_en);
    do_ref(1'b0, a, 4'h5, 8, 0);
    chk("hit flag", 32'h0, was_miss);
    chk("hit next addr", 32'hFFFFFFFF, t_na);
    chk("hit sys", 32'hFFFFFFFF, t_sys);
    chk("hit ready", 32'h2, t_rdy);
    chk("hit oe time", 32'h1, t_sr);
    chk("hit oe bank", 32'h1, bank_ok(sr_hit.oe_n));
    chk("hit bytes", 32'h5, sr_hit.byte_sel_n);
  endtask : s_read
  // Posted write, hit or miss, bus possibly held by another master
  task automatic s_write(input logic [29:0] a, input logic [3:0] be, input logic hit,
                         input int rel);
    do_ref(1'b1, a, be, 30, rel);
    chk("w ready", 32'h1, t_rdy);
    chk("w ready count", 32'h1, n_rdy);
    chk("w sys late", 32'h1, t_sys > rel);
    chk("w data", {2'h0, a}, cyc_at.data);
    chk("w bytes", be, cyc_at.be_n);
    chk("w dir", 32'h1, cyc_at.write);
    chk("w addr", a, cyc_at.addr);
    chk("w regs", 32'h1, reg_at);
    chk("w regs freed", 32'h0, reg_en);
    chk("w cache", hit, t_sr == 1);
    if (hit) chk("w sel", be, sr_hit.byte_sel_n);
  endtask : s_write
  // Second write waits while the first is still posted
  task automatic s_post_twice();
    do_ref(1'b1, 30'h0000155, 4'h0, 2, 40);
    do_ref(1'b1, 30'h00002AA, 4'h0, 40, 6);
    chk("second taken late", 32'h1, t_lat > 6);
    chk("second ready", t_lat, t_rdy);
    chk("single ready", 32'h1, n_rdy);
    chk("first kept", 32'h155, cyc_at.addr);
  endtask : s_post_twice
  // ----------------------------------------
  // Main sequence, direct then two-way
  // ----------------------------------------
  initial begin
    rst_i = 1'b1;
    two_way = 1'b0;
    ads_n = 1'b1;
    wr = 1'b0;
    addr = 30'h0;
    be_n = 4'hF;
    data = 32'h0;
    busy_cmd = 1'b0;
    waits = 4'h0;
    for (int m = 0; m < 2; m++) begin
      @(posedge mclk_i);
      rst_i <= 1'b1;
      two_way <= m[0];
      waits <= m[0] ? 4'h5 : 4'h0;
      repeat (12) @(posedge mclk_i);
      rst_i <= 1'b0;
      s_read(30'h0001234);
      s_write(30'h0001234, 4'h6, 1'b1, 0);
      s_write(30'h2000777, 4'h0, 1'b0, 10);
      s_read(30'h2000777);
      s_post_twice();
    end
    results();
  end
endmodule : wtcc_ctrl_bench
`default_nettype wire
